// ---- dv/device_reset_control_test.sv ----
`timescale 1ns/1ps
module device_reset_control_test;
  import drc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       tst_n   = 1'b1;
  logic [7:0] pins    = 8'ha5;
  wire        rst_n, sw, core_n, host_n, test_n, swq, rdy;
  wire  [7:0] strap;
  int         mismatches = 0;
  int         checked    = 0;
  int         cyc        = 0;
  always #10 ref_clk = ~ref_clk;
  drc_board_model drc_board_model_inst (.ref_clk_i(ref_clk), .rst_n_o(rst_n), .sw_o(sw));
  drc_reset_top drc_reset_top_inst (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .test_port_reset_pin_n_i(tst_n), .master_control_one_sw_rst_i(sw),
    .strap_pins_i(pins), .core_rst_n_o(core_n), .host_if_rst_n_o(host_n),
    .test_rst_n_o(test_n), .strap_o(strap), .sw_rst_o(swq), .init_ready_o(rdy));
  // ---------------------------------------------------------------
  // compare and close
  // ---------------------------------------------------------------
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // resets as one vector: core, host, test
  task automatic cmp_rst(input logic [2:0] e);
    cmp("core_host_test", {5'h00, e}, {5'h00, core_n, host_n, test_n});
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_pin;
    pins = 8'h5a;
    fork
      drc_board_model_inst.pin_pulse();
      begin
        @(negedge rst_n) #1;
        cmp_rst(3'h1);
        cmp("strap", STRAP_RESET, strap);
      end
    join
    @(negedge ref_clk);
    cmp_rst(3'h1);
    @(negedge ref_clk);
    cmp_rst(3'h7);
    @(negedge ref_clk);
    cmp("strap", 8'h5a, strap);
    $display("pin reset done");
  endtask
  task automatic t_sw;
    pins = 8'h3c;
    drc_board_model_inst.sw_set(1'b1);
    @(negedge ref_clk);
    cmp_rst(3'h3);
    cmp("swq", 8'h01, {7'h00, swq});
    cmp("rdy", 8'h00, {7'h00, rdy});
    drc_board_model_inst.host_init(rdy);
    cmp("init", 8'h00, 8'(drc_board_model_inst.init_writes));
    drc_board_model_inst.sw_set(1'b0);
    repeat (2) @(negedge ref_clk);
    cmp_rst(3'h7);
    cmp("strap", 8'h5a, strap);
    // ready must not come early yet must come within the window
    drc_board_model_inst.host_settle(SETTLE_CYCLES - 10);
    cmp("rdy", 8'h00, {7'h00, rdy});
    repeat (20) @(negedge ref_clk);
    cmp("rdy", 8'h01, {7'h00, rdy});
    drc_board_model_inst.host_init(rdy);
    cmp("init", 8'h01, 8'(drc_board_model_inst.init_writes));
    $display("software reset done");
  endtask
  task automatic t_test;
    @(negedge ref_clk);
    tst_n = 1'b0;
    repeat (PIN_MIN_CYCLES) @(negedge ref_clk);
    cmp_rst(3'h6);
    cmp("rdy", 8'h01, {7'h00, rdy});
    tst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp_rst(3'h7);
    $display("test port reset done");
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    t_pin();
    t_sw();
    t_test();
    finish_test();
  end
endmodule // device_reset_control_test

// ---- dv/drc_board_model.sv ----
`timescale 1ns/1ps
// board reset source and host software bit, both changed on falling edges
module drc_board_model
  import drc_pkg::*;
(
  input  wire logic ref_clk_i,
  output logic      rst_n_o,
  output logic      sw_o
);
  // pin held low from power-up while the oscillator settles
  initial begin
    rst_n_o = 1'b0;
    sw_o    = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_n_o = 1'b1;
  end
  // never shorter than the minimum pulse, the device may not see less
  task automatic pin_pulse;
    @(negedge ref_clk_i);
    rst_n_o = 1'b0;
    repeat (PIN_MIN_CYCLES) @(negedge ref_clk_i);
    rst_n_o = 1'b1;
  endtask
  task automatic sw_set(input logic v);
    @(negedge ref_clk_i);
    sw_o = v;
  endtask
  // host software: init writes issued since power-up
  int init_writes = 0;
  // software keeps off the device through the settle time
  task automatic host_settle(input int unsigned n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // the init script runs only once the device reports settled
  task automatic host_init(input logic settled);
    if (settled === 1'b1) init_writes++;
  endtask
endmodule // drc_board_model

// ---- hdl/drc_reset_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - three reset sources exist: the reset pin, the software bit, and the test-port reset pin.
// - the reset pin resets everything asynchronously except the test-access logic and the two strap synchroniser flops.
// - while the pin is low all registers but the test logic and strap synchroniser hold defaults; straps are captured on release.
// - the software bit resets all but the host interface, test logic, the strap synchroniser and latch, and the bit itself.
// - a software reset restores straps latched at the last pin reset, not the pins.
module drc_reset_top
  import drc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        test_port_reset_pin_n_i,
  input  wire logic        master_control_one_sw_rst_i,
  input  wire logic [7:0]  strap_pins_i,
  output logic             core_rst_n_o,
  output logic             host_if_rst_n_o,
  output logic             test_rst_n_o,
  output logic [7:0]       strap_o,
  output logic             sw_rst_o,
  output logic             init_ready_o
);

  // ----------------------------------------------------------------
  // pin reset synchroniser
  // ----------------------------------------------------------------
  logic pin_s1;
  logic pin_s2;

  // asserts at once, releases on a clock edge so all logic leaves together;
  // a plain async release could free some flops a cycle before others
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= 1'b1;
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------------------------------
  // software reset bit
  // ----------------------------------------------------------------
  logic sw_rst;

  // the bit lives in the host domain and is cleared only by the pin, not by itself;
  // it comes from logic on this clock, so one register is enough and the
  // core drops on the edge after the bit is set
  always_ff @(posedge ref_clk_i or negedge pin_s2) begin
    if (!pin_s2) begin
      sw_rst <= 1'b0;
    end else begin
      sw_rst <= master_control_one_sw_rst_i;
    end
  end

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  logic test_s1;
  logic test_s2;
  wire  core_rst_n = pin_s2 & ~sw_rst;

  // test logic follows its own pin only; the device pin never touches it,
  // so a board reset cannot disturb a scan or boundary test in progress
  always_ff @(posedge ref_clk_i or negedge test_port_reset_pin_n_i) begin
    if (!test_port_reset_pin_n_i) begin
      test_s1 <= 1'b0;
      test_s2 <= 1'b0;
    end else begin
      test_s1 <= 1'b1;
      test_s2 <= test_s1;
    end
  end

  assign core_rst_n_o    = core_rst_n;
  assign host_if_rst_n_o = pin_s2;
  assign test_rst_n_o    = test_s2;
  assign sw_rst_o        = sw_rst;

  // ----------------------------------------------------------------
  // strap handling
  // ----------------------------------------------------------------
  drc_rst_if rst_bus ();
  assign rst_bus.core_rst_n = core_rst_n;
  assign rst_bus.pin_rst_n  = pin_s2;
  assign strap_o            = rst_bus.strap_q;

  drc_strap_hold u_strap (
    .ref_clk_i    (ref_clk_i),
    .strap_pins_i (strap_pins_i),
    .rst_bus      (rst_bus.snk)
  );

  // ----------------------------------------------------------------
  // settle timer
  // ----------------------------------------------------------------
  // flags when software may begin its init writes; purely informative,
  // the device does not block early accesses
  logic [12:0] settle_cnt;
  logic        ready;

  always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      settle_cnt <= 13'h0000;
      ready      <= 1'b0;
    end else if (!ready) begin
      settle_cnt <= settle_cnt + 13'h0001;
      ready      <= (settle_cnt == 13'(SETTLE_CYCLES - 1));
    end
  end

  assign init_ready_o = ready;

  // ----------------------------------------------------------------
  // checks: reset scope
  // ----------------------------------------------------------------
  // the device pin pulls core and host interface down together
  property p_pin_to_all;
    @(posedge ref_clk_i) !pin_s2 |-> (!core_rst_n && !host_if_rst_n_o);
  endproperty
  a_pin_to_all : assert property (p_pin_to_all) else $error("pin reset not global");

  // the software bit drops the core but leaves the host side alive,
  // otherwise software could never write the bit back to zero
  property p_sw_spares_host;
    @(posedge ref_clk_i) disable iff (!pin_s2) sw_rst |-> (!core_rst_n_o && host_if_rst_n_o);
  endproperty
  a_sw_spares_host : assert property (p_sw_spares_host)
    else $error("software reset scope wrong");

  // a set bit takes the core down one edge later, never later still
  property p_sw_one_late;
    @(posedge ref_clk_i) disable iff (!pin_s2)
      (pin_s2 && master_control_one_sw_rst_i) |=> !core_rst_n_o;
  endproperty
  a_sw_one_late : assert property (p_sw_one_late)
    else $error("software reset not taken");

  // the test-access reset ignores the device pin entirely
  property p_test_apart;
    @(posedge ref_clk_i)
      (test_s2 && test_port_reset_pin_n_i) ##1 test_port_reset_pin_n_i |-> test_rst_n_o;
  endproperty
  a_test_apart : assert property (p_test_apart)
    else $error("test reset followed the device pin");

  // ----------------------------------------------------------------
  // checks: release timing
  // ----------------------------------------------------------------
  // the pin goes high and stays high for the two synchroniser edges
  sequence s_pin_free;
    $rose(rst_n_i) ##1 rst_n_i ##1 rst_n_i;
  endsequence

  // same release shape for the test port pin
  sequence s_test_free;
    $rose(test_port_reset_pin_n_i) ##1 test_port_reset_pin_n_i ##1 test_port_reset_pin_n_i;
  endsequence

  // nothing leaves reset before the second edge after the pin lets go
  property p_host_not_early;
    @(posedge ref_clk_i) $rose(rst_n_i) |-> !host_if_rst_n_o ##1 !host_if_rst_n_o;
  endproperty
  a_host_not_early : assert property (p_host_not_early)
    else $error("host reset released too early");

  // and the host side is out of reset once the second edge has passed
  property p_host_two_edges;
    @(posedge ref_clk_i) s_pin_free |-> host_if_rst_n_o;
  endproperty
  a_host_two_edges : assert property (p_host_two_edges)
    else $error("host reset release late");

  // the test port has its own two-stage release, independent of the pin
  property p_test_two_edges;
    @(posedge ref_clk_i) s_test_free |-> test_rst_n_o;
  endproperty
  a_test_two_edges : assert property (p_test_two_edges)
    else $error("test reset release late");

  // the second stage only rises when the first was already high
  property p_sync_release;
    @(posedge ref_clk_i) $rose(pin_s2) |-> $past(pin_s1);
  endproperty
  a_sync_release : assert property (p_sync_release)
    else $error("release not synchronised");

  // the core follows a clock edge too, whichever source lets it go
  property p_core_on_edge;
    @(posedge ref_clk_i) $rose(core_rst_n) |-> ($past(pin_s1) && !sw_rst);
  endproperty
  a_core_on_edge : assert property (p_core_on_edge)
    else $error("core release off the clock");

  // ----------------------------------------------------------------
  // checks: settle timer
  // ----------------------------------------------------------------
  // one core reset release, the step that restarts the settle timer
  sequence s_rel;
    !core_rst_n ##1 core_rst_n;
  endsequence

  // a freshly released core never reports ready in its first cycles
  property p_ready_late;
    @(posedge ref_clk_i) disable iff (!core_rst_n) s_rel |-> !ready [*8];
  endproperty
  a_ready_late : assert property (p_ready_late) else $error("ready too early");

  // ready comes exactly at the end of the count; the counter then freezes
  property p_ready_count;
    @(posedge ref_clk_i) disable iff (!core_rst_n) ready |-> (settle_cnt == 13'(SETTLE_CYCLES));
  endproperty
  a_ready_count : assert property (p_ready_count)
    else $error("ready off the settle count");

endmodule // drc_reset_top

// ---- hdl/drc_strap_hold.sv ----
`timescale 1ns/1ps
module drc_strap_hold
  import drc_pkg::*;
(
  input  wire logic           ref_clk_i,
  input  wire logic [7:0]     strap_pins_i,
  drc_rst_if.snk              rst_bus
);

  // --------------------------------------------------------------
  // strap capture
  // --------------------------------------------------------------
  logic [7:0] strap_s1;
  logic [7:0] strap_s2;
  logic [7:0] strap_lat;
  logic       pin_rst_d;
  wire        pin_release = rst_bus.pin_rst_n & ~pin_rst_d;

  // the pins pass two flops before anything reads them; the pair keeps
  // running through reset so that it is settled when the pin reset lets go
  always_ff @(posedge ref_clk_i) begin
    strap_s1 <= strap_pins_i;
    strap_s2 <= strap_s1;
  end

  // marks the first cycle after the pin reset lets go; a software reset
  // never touches it, so the straps are never sampled again then
  always_ff @(posedge ref_clk_i or negedge rst_bus.pin_rst_n) begin
    if (!rst_bus.pin_rst_n) begin
      pin_rst_d <= 1'b0;
    end else begin
      pin_rst_d <= 1'b1;
    end
  end

  // latched copy survives software resets
  always_ff @(posedge ref_clk_i or negedge rst_bus.pin_rst_n) begin
    if (!rst_bus.pin_rst_n) begin
      strap_lat <= STRAP_RESET;
    end else if (pin_release) begin
      strap_lat <= strap_s2;
    end
  end

  // core copy: reset by both sources, reloaded from the latched value
  always_ff @(posedge ref_clk_i or negedge rst_bus.core_rst_n) begin
    if (!rst_bus.core_rst_n) begin
      rst_bus.strap_q <= STRAP_RESET;
    end else begin
      rst_bus.strap_q <= pin_release ? strap_s2 : strap_lat;
    end
  end

  // the latch only moves on the release of the pin reset
  property p_no_resample;
    @(posedge ref_clk_i) disable iff (!rst_bus.pin_rst_n) !pin_release |=> $stable(strap_lat);
  endproperty
  a_no_resample : assert property (p_no_resample)
    else $error("strap latch changed outside pin release");

  // on release the latch takes the synchronised pin value
  property p_strap_capture;
    @(posedge ref_clk_i) disable iff (!rst_bus.pin_rst_n)
      pin_release |=> (strap_lat == $past(strap_s2));
  endproperty
  a_strap_capture : assert property (p_strap_capture)
    else $error("strap latch missed the pin value");

  // outside the release cycle the core copy is reloaded from the latch only
  property p_strap_reload;
    @(posedge ref_clk_i) disable iff (!rst_bus.core_rst_n)
      (rst_bus.core_rst_n && !pin_release) |=> (rst_bus.strap_q == $past(strap_lat));
  endproperty
  a_strap_reload : assert property (p_strap_reload)
    else $error("strap copy not taken from the latch");

endmodule // drc_strap_hold

// ---- shared/drc_pkg.sv ----
package drc_pkg;
  // width of the pin-strapped configuration field
  localparam int unsigned STRAP_W          = 8;
  localparam logic [7:0]  STRAP_RESET      = 8'h00;
  // reference clock rate and the settle time software must honour
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned SETTLE_US        = 100;
  localparam int unsigned SETTLE_CYCLES    = (SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PIN_MIN_NS       = 100;
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned PIN_MIN_CYCLES   = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES      = 2;
endpackage

// ---- shared/drc_rst_if.sv ----
`timescale 1ns/1ps
// carries the combined core reset and the strap value between the two modules
interface drc_rst_if;
  logic                 core_rst_n;
  logic                 pin_rst_n;
  logic [7:0]           strap_q;
  modport src (output core_rst_n, output pin_rst_n, input strap_q);
  modport snk (input core_rst_n, input pin_rst_n, output strap_q);
endinterface
